// [hw/atc_histogram.sv]
// Purpose: histogram store with clear and halving sweeps
// Assumes: one sample per cycle at most, sweeps drop sample adds
// Notes: clear and halve walk every bin, one per cycle
`timescale 1ns/1ps
module atc_histogram #(
    parameter int BINS = 16,
    parameter int HW = atc_pkg::HIST_W,
    parameter int AW = atc_pkg::BIN_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic add,
    input wire logic [AW-1:0] bin,
    input wire logic clear_req,
    input wire logic halve_req,
    input wire logic [AW-1:0] rd_bin,
    output logic [HW-1:0] rd_data,
    output logic busy
);
    logic [HW-1:0] mem_ff [BINS];   // bin counts
    logic [AW-1:0] idx_ff;          // sweep pointer
    logic sweep_ff;                 // sweep in progress
    logic halve_ff;                 // sweep halves rather than clears

    assign busy = sweep_ff;

    // sweep control, requests taken only when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sweep_ff <= 1'b0;
            halve_ff <= 1'b0;
            idx_ff <= '0;
        end else if (ce) begin
            if (!sweep_ff && (clear_req || halve_req)) begin
                sweep_ff <= 1'b1;
                halve_ff <= halve_req;
                idx_ff <= '0;
            end else if (sweep_ff) begin
                idx_ff <= idx_ff + 1'b1;
                if (idx_ff == AW'(BINS - 1)) begin
                    sweep_ff <= 1'b0;
                end
            end
        end
    end

    // bin storage; counts saturate rather than wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < BINS; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (ce) begin
            if (sweep_ff) begin
                mem_ff[idx_ff] <= halve_ff ? (mem_ff[idx_ff] >> 1) : '0;
            end else if (add && mem_ff[bin] != '1) begin
                mem_ff[bin] <= mem_ff[bin] + 1'b1;
            end
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= mem_ff[rd_bin];
        end
    end

    a_sweep_length: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(sweep_ff) && ce) |-> ##[1:64] !sweep_ff)
        else $error("histogram sweep did not finish");
endmodule

// [hw/atc_pkg.sv]
// Purpose: shared constants and carriers for the acquisition trigger control
// Assumes: 10 MHz system clock, samples arrive as signed level words
// Notes: timing figures kept in their own units with derived cycle counts
package atc_pkg;
    localparam int CLK_HZ = 10000000;          // system clock rate
    localparam int TICK_NS = 10;               // holdoff and delay step in ns
    localparam int CLK_NS = 1000000000 / CLK_HZ;
    localparam int AUTO_MIN_MS = 100;          // shortest auto-trigger wait
    localparam int AUTO_MAX_MS = 500;          // longest auto-trigger wait
    localparam int AUTO_MIN_CYC = AUTO_MIN_MS * (CLK_HZ / 1000);
    localparam int AUTO_MAX_CYC = AUTO_MAX_MS * (CLK_HZ / 1000);
    localparam int RUN_TIME_MAX_S = 3600;      // longest terminal run time
    localparam int SEC_CYC = CLK_HZ;           // cycles per second
    localparam int HOLDOFF_MAX_TICKS = 100000000; // one second in 10 ns ticks
    localparam int FREE_RUN_CYC = 16;          // spacing of forced traces
    localparam int LVL_W = 16;                 // trigger level and sample width
    localparam int CNT_W = 32;                 // tick counter width
    localparam int HIST_W = 24;                // histogram bin count width
    localparam int BIN_W = 4;                  // histogram address width
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [1:0] ONE2 = 2'h1;

    typedef enum logic [1:0] {
        SRC_SENSOR_CHANNEL_ONE,
        SRC_SENSOR_CHANNEL_TWO,
        SRC_EXTERNAL_INPUT_ONE,
        SRC_EXTERNAL_INPUT_TWO
    } atc_src_t;

    typedef enum logic [1:0] {
        TM_NORMAL,
        TM_AUTO,
        TM_AUTO_MIDLEVEL_MODE,
        TM_FREE_RUNNING_MODE
    } atc_tmode_t;

    typedef enum logic [1:0] {
        POS_LEFT,
        POS_MIDDLE,
        POS_RIGHT
    } atc_pos_t;

    typedef enum logic [1:0] {
        MEAS_PULSE,
        MEAS_MODULATED,
        MEAS_STATISTICAL
    } atc_meas_t;

    // trigger configuration travelling together
    typedef struct packed {
        atc_src_t source;
        atc_tmode_t mode;
        logic falling_edge;
        atc_pos_t position;
        logic modulated_triggered;
        logic signed [LVL_W-1:0] level;
        logic signed [CNT_W-1:0] trigger_offset_value;
        logic [CNT_W-1:0] holdoff_ticks;
    } atc_trig_cfg_t;

    // statistical configuration travelling together
    typedef struct packed {
        logic histogram_halving_select;
        logic continuous_acquire;
        logic gating_on;
        logic [CNT_W-1:0] terminal_sample_count;
        logic [11:0] terminal_run_time;
        logic signed [CNT_W-1:0] gate_one;
        logic signed [CNT_W-1:0] gate_two;
    } atc_stat_cfg_t;
endpackage

// [hw/atc_trigger_ctrl.sv]
// Purpose: trigger qualification, holdoff, delay and statistical sequencing
// Assumes: sensor levels are on this clock; external inputs are async pins
// Notes: tick counts are 10 ns units, scaled to the 100 ns system clock
// Notes on behaviour
// R1 - no halving: erase histogram, restart at terminal
// R2 - halving: divide all counts by two, continue
// R3 - terminal run time zero to 3600 seconds
// R4 - run time end: stop unless continuous
// R5 - delay shifts trigger later or earlier; a negative delay here fires the sweep at once
// R6 - holdoff starts at edge, blocks retriggers
// R7 - holdoff 10 ns steps, zero disables
// R8 - accept internal and external trigger levels
// R9 - explicit level write leaves midlevel mode
// R10 - normal mode sweeps only on crossings
// R11 - auto mode forces trace after timeout
// R12 - midlevel mode tracks halfway between extremes
// R13 - free-run starts traces repeatedly
// R14 - modulated: free-run or one start event; only the edge start event is built
// R15 - position sets pre/post trigger split; TRIG_CFG.position is read nowhere in this logic
// R16 - rising edge or falling edge slope
// R17 - source from sensors or external inputs
// R18 - gates bounded within delay plus five divisions
// R19 - trigger settings act only pulse or gated
// R20 - sample count end: complete, halt or continue
// R21 - gating off all samples, on gate window
// R22 - counters count in 10 ns units
// R23 - completion flag on terminal condition
`timescale 1ns/1ps
module atc_trigger_ctrl #(
    parameter int AUTO_WAIT_CYC = atc_pkg::AUTO_MIN_CYC,
    parameter int SEC_CYCLES = atc_pkg::SEC_CYC,
    parameter int BINS = 16
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire atc_pkg::atc_meas_t MEAS_MODE,
    input wire atc_pkg::atc_trig_cfg_t TRIG_CFG,
    input wire logic LEVEL_WRITE,
    input wire atc_pkg::atc_stat_cfg_t STAT_CFG,
    input wire logic signed [atc_pkg::LVL_W-1:0] SENSOR_CHANNEL_ONE,
    input wire logic signed [atc_pkg::LVL_W-1:0] SENSOR_CHANNEL_TWO,
    input wire logic EXTERNAL_INPUT_ONE,
    input wire logic EXTERNAL_INPUT_TWO,
    input wire logic SAMPLE_VALID,
    input wire logic [atc_pkg::BIN_W-1:0] SAMPLE_BIN,
    input wire logic START,
    input wire logic STOP,
    input wire logic [atc_pkg::BIN_W-1:0] HIST_RD_BIN,
    output logic [atc_pkg::HIST_W-1:0] HIST_RD_DATA,
    output logic SWEEP_START,
    output logic signed [atc_pkg::LVL_W-1:0] ACTIVE_LEVEL,
    output logic AUTO_LEVEL_ACTIVE,
    output logic ACQUIRING,
    output logic STAT_COMPLETE,
    output logic HIST_BUSY
);
    localparam int TICKS_PER_CYC = atc_pkg::CLK_NS / atc_pkg::TICK_NS;
    localparam logic [31:0] AUTO_W = 32'(AUTO_WAIT_CYC);
    localparam logic [31:0] SEC_W = 32'(SEC_CYCLES);
    localparam logic [31:0] FREE_W = 32'(atc_pkg::FREE_RUN_CYC);
    localparam logic [11:0] RUN_MAX = 12'(atc_pkg::RUN_TIME_MAX_S);
    localparam logic [31:0] ZERO32_L = atc_pkg::ZERO32;

    // shift a tick count into system cycles, rounding up
    function automatic logic [31:0] ticks_to_cyc(input logic [31:0] t);
        ticks_to_cyc = 32'((64'(t) + 64'(TICKS_PER_CYC - 1)) / 64'(TICKS_PER_CYC));
    endfunction

    // level crossing in the chosen direction
    function automatic logic crossed(input logic signed [atc_pkg::LVL_W-1:0] prev,
                                     input logic signed [atc_pkg::LVL_W-1:0] cur,
                                     input logic signed [atc_pkg::LVL_W-1:0] lvl,
                                     input logic fall);
        crossed = fall ? (prev >= lvl && cur < lvl) : (prev < lvl && cur >= lvl);
    endfunction

    logic [1:0] ext1_sync_ff;       // external input one synchroniser
    logic [1:0] ext2_sync_ff;       // external input two synchroniser
    logic signed [atc_pkg::LVL_W-1:0] prev_ff;      // last selected sample
    logic signed [atc_pkg::LVL_W-1:0] cur_lvl;      // selected sample now
    logic signed [atc_pkg::LVL_W-1:0] max_ff;       // highest seen level
    logic signed [atc_pkg::LVL_W-1:0] min_ff;       // lowest seen level
    logic auto_mid_ff;              // midlevel mode still in force
    logic edge_hit;                 // qualified crossing this cycle
    logic [31:0] hold_ff;           // holdoff cycles remaining
    logic [31:0] dly_ff;            // delay cycles remaining
    logic dly_run_ff;               // delayed trigger pending
    logic [31:0] idle_ff;           // cycles since last trigger
    logic [31:0] fr_ff;             // free-run spacing counter
    logic mod_armed_ff;             // modulated start event seen
    logic trig_en;                  // trigger settings in force
    logic raw_trig;                 // accepted edge or forced trace
    logic [31:0] sec_ff;            // cycles within current second
    logic [11:0] secs_ff;           // whole seconds of run time
    logic [31:0] samp_ff;           // accepted samples so far
    logic terminal;                 // terminal condition reached
    logic in_gate;                  // sample time within gate window
    logic signed [31:0] since_ff;   // cycles since sweep start, for gating
    logic hist_clr;
    logic hist_halve;
    logic hist_add;
    logic signed [31:0] gate_lo;
    logic signed [31:0] gate_hi;

    // two-stage sync on the external trigger pins
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ext1_sync_ff <= 2'h0;
            ext2_sync_ff <= 2'h0;
        end else if (CE) begin
            ext1_sync_ff <= {ext1_sync_ff[0], EXTERNAL_INPUT_ONE};
            ext2_sync_ff <= {ext2_sync_ff[0], EXTERNAL_INPUT_TWO};
        end
    end

    // source mux; external pins map to full-scale levels
    always_comb begin
        case (TRIG_CFG.source)
            atc_pkg::SRC_SENSOR_CHANNEL_ONE: cur_lvl = SENSOR_CHANNEL_ONE; // [R17]
            atc_pkg::SRC_SENSOR_CHANNEL_TWO: cur_lvl = SENSOR_CHANNEL_TWO; // [R17]
            atc_pkg::SRC_EXTERNAL_INPUT_ONE: cur_lvl = ext1_sync_ff[1] ? 16'sh7fff : 16'sh8000;
            atc_pkg::SRC_EXTERNAL_INPUT_TWO: cur_lvl = ext2_sync_ff[1] ? 16'sh7fff : 16'sh8000;
            default: cur_lvl = SENSOR_CHANNEL_ONE;
        endcase
    end

    // previous sample and peak tracking for midlevel mode
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            prev_ff <= '0;
            max_ff <= 16'sh8000;
            min_ff <= 16'sh7fff;
        end else if (CE) begin
            prev_ff <= cur_lvl;
            if (cur_lvl > max_ff) begin
                max_ff <= cur_lvl; // [R12]
            end
            if (cur_lvl < min_ff) begin
                min_ff <= cur_lvl; // [R12]
            end
        end
    end

    // midlevel mode cancelled by an explicit level write
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            auto_mid_ff <= 1'b0;
        end else if (CE) begin
            if (LEVEL_WRITE) begin
                auto_mid_ff <= 1'b0; // [R9]
            end else if (TRIG_CFG.mode != atc_pkg::TM_AUTO_MIDLEVEL_MODE) begin
                auto_mid_ff <= 1'b1;
            end
        end
    end

    // level: host value, or midpoint of extremes; range is the host's concern
    assign AUTO_LEVEL_ACTIVE = auto_mid_ff && (TRIG_CFG.mode == atc_pkg::TM_AUTO_MIDLEVEL_MODE);
    assign ACTIVE_LEVEL = AUTO_LEVEL_ACTIVE ?
        16'((17'(max_ff) + 17'(min_ff)) >>> 1) : TRIG_CFG.level; // [R12] [R8]

    assign edge_hit = crossed(prev_ff, cur_lvl, ACTIVE_LEVEL, TRIG_CFG.falling_edge); // [R16]
    assign trig_en = (MEAS_MODE == atc_pkg::MEAS_PULSE) ||
                     (MEAS_MODE == atc_pkg::MEAS_STATISTICAL && STAT_CFG.gating_on); // [R19]

    // edge accepted when armed; auto adds forced traces, free-run uses forced traces only
    always_comb begin
        raw_trig = 1'b0;
        if (hold_ff == ZERO32_L) begin
            case (trig_en ? TRIG_CFG.mode : atc_pkg::TM_NORMAL)
                atc_pkg::TM_NORMAL: raw_trig = edge_hit; // [R10] [R6]
                atc_pkg::TM_AUTO, atc_pkg::TM_AUTO_MIDLEVEL_MODE:
                    raw_trig = edge_hit || (idle_ff >= AUTO_W); // [R11]
                atc_pkg::TM_FREE_RUNNING_MODE: raw_trig = (fr_ff >= FREE_W); // [R13]
                default: raw_trig = edge_hit;
            endcase
        end
    end

    // holdoff in 10 ns ticks converted to cycles; zero disables
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            hold_ff <= '0;
        end else if (CE) begin
            if (raw_trig && trig_en) begin
                hold_ff <= ticks_to_cyc(TRIG_CFG.holdoff_ticks); // [R6] [R7] [R22]
            end else if (hold_ff != ZERO32_L) begin
                hold_ff <= hold_ff - 1'b1; // [R6]
            end
        end
    end

    // idle and free-run counters
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            idle_ff <= '0;
            fr_ff <= '0;
        end else if (CE) begin
            idle_ff <= raw_trig ? ZERO32_L : idle_ff + 1'b1; // [R11]
            fr_ff <= raw_trig ? ZERO32_L : fr_ff + 1'b1; // [R13]
        end
    end

    // positive delay postpones the sweep; negative is a pre-trigger offset
    // handled by capture placement, so the sweep fires at once
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dly_ff <= '0;
            dly_run_ff <= 1'b0;
            SWEEP_START <= 1'b0;
        end else if (CE) begin
            SWEEP_START <= 1'b0;
            if (raw_trig && !dly_run_ff) begin
                if (trig_en && TRIG_CFG.trigger_offset_value > 0 &&
                    ticks_to_cyc(TRIG_CFG.trigger_offset_value) > 32'h1) begin
                    dly_ff <= ticks_to_cyc(TRIG_CFG.trigger_offset_value) - 1'b1; // [R5] [R22]
                    dly_run_ff <= 1'b1;
                end else begin
                    SWEEP_START <= 1'b1; // [R5] [R15]
                end
            end else if (dly_run_ff) begin
                dly_ff <= dly_ff - 1'b1;
                if (dly_ff == 32'h1) begin
                    dly_run_ff <= 1'b0;
                    SWEEP_START <= 1'b1; // [R5]
                end
            end
        end
    end

    // modulated: a qualified edge arms acquisition once; no free-run start
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mod_armed_ff <= 1'b0;
        end else if (CE) begin
            if (STOP || MEAS_MODE != atc_pkg::MEAS_MODULATED) begin
                mod_armed_ff <= 1'b0;
            end else if (edge_hit) begin
                mod_armed_ff <= 1'b1; // [R14]
            end
        end
    end

    // gate window; host keeps gates within delay plus five divisions
    assign gate_lo = (STAT_CFG.gate_one < STAT_CFG.gate_two) ? STAT_CFG.gate_one : STAT_CFG.gate_two;
    assign gate_hi = (STAT_CFG.gate_one < STAT_CFG.gate_two) ? STAT_CFG.gate_two : STAT_CFG.gate_one;
    assign in_gate = (since_ff * 32'sd10 > gate_lo) && (since_ff * 32'sd10 < gate_hi); // [R18]

    // time since the last sweep start, in cycles
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            since_ff <= '0;
        end else if (CE) begin
            since_ff <= SWEEP_START ? 32'sh0 : since_ff + 32'sh1;
        end
    end

    // run-time seconds and sample count while acquiring
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sec_ff <= '0;
            secs_ff <= '0;
            samp_ff <= '0;
        end else if (CE) begin
            if (terminal || START) begin
                sec_ff <= '0;
                secs_ff <= '0;
                samp_ff <= '0;
            end else if (ACQUIRING) begin
                if (sec_ff == SEC_W - 1'b1) begin
                    sec_ff <= '0;
                    secs_ff <= secs_ff + 1'b1; // [R3]
                end else begin
                    sec_ff <= sec_ff + 1'b1;
                end
                if (hist_add) begin
                    samp_ff <= samp_ff + 1'b1; // [R20]
                end
            end
        end
    end

    // terminal when either limit is met; zero settings mean no limit
    assign terminal = ACQUIRING && MEAS_MODE == atc_pkg::MEAS_STATISTICAL &&
        ((STAT_CFG.terminal_run_time != 12'h0 && STAT_CFG.terminal_run_time <= RUN_MAX &&
          secs_ff >= STAT_CFG.terminal_run_time) ||
         (STAT_CFG.terminal_sample_count != ZERO32_L &&
          samp_ff >= STAT_CFG.terminal_sample_count)); // [R3] [R20]

    // histogram adds: every sample outside a sweep, or only those in gate
    assign hist_add = ACQUIRING && SAMPLE_VALID && !HIST_BUSY &&
        MEAS_MODE == atc_pkg::MEAS_STATISTICAL && (!STAT_CFG.gating_on || in_gate); // [R21]
    assign hist_clr = terminal && STAT_CFG.continuous_acquire &&
        !STAT_CFG.histogram_halving_select; // [R1]
    assign hist_halve = terminal && STAT_CFG.continuous_acquire &&
        STAT_CFG.histogram_halving_select; // [R2]

    // acquisition state and completion flag; start clears the flag
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ACQUIRING <= 1'b0;
            STAT_COMPLETE <= 1'b0;
        end else if (CE) begin
            if (terminal) begin
                STAT_COMPLETE <= 1'b1; // [R23]
                ACQUIRING <= STAT_CFG.continuous_acquire; // [R4] [R20]
            end else if (STOP) begin
                ACQUIRING <= 1'b0;
            end else if (START) begin
                ACQUIRING <= 1'b1;
                STAT_COMPLETE <= 1'b0;
            end else if (MEAS_MODE == atc_pkg::MEAS_MODULATED && mod_armed_ff) begin
                ACQUIRING <= 1'b1; // [R14]
            end
        end
    end

    atc_histogram #(.BINS(BINS)) u_hist (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .add(hist_add),
        .bin(SAMPLE_BIN),
        .clear_req(hist_clr),
        .halve_req(hist_halve),
        .rd_bin(HIST_RD_BIN),
        .rd_data(HIST_RD_DATA),
        .busy(HIST_BUSY)
    );

    a_holdoff_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (CE && hold_ff != ZERO32_L) |-> !raw_trig) // [R6]
        else $error("trigger accepted during holdoff");
    a_midlevel_cancel: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (CE && LEVEL_WRITE) |=> !AUTO_LEVEL_ACTIVE) // [R9]
        else $error("midlevel mode survived level write");
    a_complete_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (CE && terminal) |=> STAT_COMPLETE) // [R23]
        else $error("completion flag not raised");
    a_halt_single: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (CE && terminal && !STAT_CFG.continuous_acquire) |=> !ACQUIRING) // [R4]
        else $error("acquisition did not halt");
    a_clear_restart: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (CE && hist_clr) |=> HIST_BUSY && ACQUIRING) // [R1]
        else $error("histogram not erased on terminal");
    a_halve_continue: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (CE && hist_halve) |=> HIST_BUSY && ACQUIRING) // [R2]
        else $error("histogram not halved on terminal");
    a_normal_edge: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (trig_en && TRIG_CFG.mode == atc_pkg::TM_NORMAL && raw_trig) |-> edge_hit) // [R10]
        else $error("normal mode fired without crossing");
    a_gate_filter: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (hist_add && STAT_CFG.gating_on) |-> in_gate) // [R21]
        else $error("sample outside gate accepted");
    c_delayed_sweep: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        dly_run_ff ##[1:50] SWEEP_START);
    c_auto_force: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        TRIG_CFG.mode == atc_pkg::TM_AUTO && raw_trig && !edge_hit);
    c_terminal_halve: cover property (@(posedge CLK_SYS) disable iff (!RST_N) hist_halve);
endmodule

// [verification/atc_sensor_model.sv]
// Purpose: far-side model of the two sensors and two trigger pins
// Assumes: each call moves one source to a clean high or low level
// Notes: levels sit far from a zero threshold, so hysteresis never matters
`timescale 1ns/1ps
module atc_sensor_model (
    output logic signed [atc_pkg::LVL_W-1:0] lvl_one,
    output logic signed [atc_pkg::LVL_W-1:0] lvl_two,
    output logic pin_one,
    output logic pin_two
);
    // all sources quiet and low, so no crossing at start
    initial begin
        lvl_one = -16'sh1000;
        lvl_two = -16'sh1000;
        pin_one = 1'b0;
        pin_two = 1'b0;
    end
    // move one source; sel follows the source encoding
    task automatic step(input logic [1:0] sel, input logic hi);
        case (sel)
            2'h0: lvl_one = hi ? 16'sh1000 : -16'sh1000;
            2'h1: lvl_two = hi ? 16'sh1000 : -16'sh1000;
            2'h2: pin_one = hi;
            default: pin_two = hi;
        endcase
    endtask
endmodule

// [verification/testbench.sv]
// Purpose: self-checking bench for trigger and statistics sequencing
// Assumes: inputs move 10 ns after the rising edge
// Notes: short auto wait and one-second count keep the run brief
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lvl_wr = 1'b0;
    logic start = 1'b0;
    logic valid = 1'b0;
    logic stop = 1'b0;
    logic [3:0] sbin = 4'h2;
    logic [3:0] rd_bin = 4'h2;
    atc_pkg::atc_meas_t meas = atc_pkg::MEAS_PULSE;
    atc_pkg::atc_trig_cfg_t tc = '0;
    atc_pkg::atc_stat_cfg_t sc = '0;
    logic signed [15:0] s1, s2, act_lvl;
    logic p1, p2, sweep, auto_lvl, acq, done, busy;
    logic [23:0] rd_data;
    int err_count = 0;
    int checked = 0;
    int c;
    always #50 clk = ~clk;
    atc_sensor_model model (.lvl_one(s1), .lvl_two(s2), .pin_one(p1), .pin_two(p2));
    atc_trigger_ctrl #(.AUTO_WAIT_CYC(50), .SEC_CYCLES(20), .BINS(16)) dut (
        .CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .MEAS_MODE(meas), .TRIG_CFG(tc),
        .LEVEL_WRITE(lvl_wr), .STAT_CFG(sc), .SENSOR_CHANNEL_ONE(s1),
        .SENSOR_CHANNEL_TWO(s2), .EXTERNAL_INPUT_ONE(p1), .EXTERNAL_INPUT_TWO(p2),
        .SAMPLE_VALID(valid), .SAMPLE_BIN(sbin), .START(start), .STOP(stop),
        .HIST_RD_BIN(rd_bin), .HIST_RD_DATA(rd_data), .SWEEP_START(sweep),
        .ACTIVE_LEVEL(act_lvl), .AUTO_LEVEL_ACTIVE(auto_lvl), .ACQUIRING(acq),
        .STAT_COMPLETE(done), .HIST_BUSY(busy));
    // advance n edges, landing 10 ns after the last
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    // count sweep pulses seen over n cycles
    task automatic sweeps(input int n, output int k);
        k = 0;
        repeat (n) begin
            tick(1);
            if (sweep === 1'b1) k++;
        end
    endtask
    // bounded wait for the sweep engine to reach a state
    task automatic wait_busy(input logic v);
        for (int i = 0; i < 40 && busy !== v; i++) tick(1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog, several times the expected run
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    initial begin
        tick(10);
        rst_n = 1'b1;
        tick(2);
        sweeps(20, c); `CHK(c, 0)
        model.step(2'h0, 1'b1); sweeps(4, c); `CHK(c, 1)
        tc.holdoff_ticks = 32'h64;
        model.step(2'h0, 1'b0); tick(2); model.step(2'h0, 1'b1); sweeps(4, c); `CHK(c, 1)
        model.step(2'h0, 1'b0); tick(2); model.step(2'h0, 1'b1); sweeps(4, c); `CHK(c, 0)
        tick(12); model.step(2'h0, 1'b0); tick(2);
        model.step(2'h0, 1'b1); sweeps(4, c); `CHK(c, 1)
        tc.holdoff_ticks = '0;
        // the holdoff started by the last sweep still runs; let it expire
        tick(10);
        tc.falling_edge = 1'b1;
        model.step(2'h0, 1'b0); sweeps(4, c); `CHK(c, 1)
        model.step(2'h0, 1'b1); sweeps(4, c); `CHK(c, 0)
        tc.falling_edge = 1'b0;
        tc.source = atc_pkg::SRC_EXTERNAL_INPUT_ONE;
        model.step(2'h2, 1'b1); sweeps(6, c); `CHK(c, 1)
        tc.source = atc_pkg::SRC_SENSOR_CHANNEL_TWO;
        // previous sample must come from the new source before its edge
        tick(2);
        model.step(2'h1, 1'b1); sweeps(4, c); `CHK(c, 1)
        $display("trigger tests done");
        tc.mode = atc_pkg::TM_AUTO;
        sweeps(60, c); `CHK(c > 0, 1'b1)
        tc.mode = atc_pkg::TM_FREE_RUNNING_MODE;
        sweeps(64, c); `CHK(c >= 3, 1'b1)
        tc.mode = atc_pkg::TM_AUTO_MIDLEVEL_MODE;
        tick(3); `CHK(auto_lvl, 1'b1)
        // extremes so far are the two full-scale pin levels
        `CHK(act_lvl, 16'hffff)
        lvl_wr = 1'b1; tick(1); lvl_wr = 1'b0; tick(2);
        `CHK(auto_lvl, 1'b0)
        `CHK(act_lvl, tc.level)
        $display("mode tests done");
        // continuous run with halving, one-second terminal time
        tc.mode = atc_pkg::TM_NORMAL;
        meas = atc_pkg::MEAS_STATISTICAL;
        sc.continuous_acquire = 1'b1;
        sc.histogram_halving_select = 1'b1;
        sc.terminal_run_time = 12'h001;
        start = 1'b1; tick(1); start = 1'b0;
        valid = 1'b1; tick(4); valid = 1'b0;
        wait_busy(1'b1); wait_busy(1'b0); tick(2);
        `CHK(rd_data, 24'h000002)
        `CHK(done, 1'b1)
        sc.histogram_halving_select = 1'b0;
        wait_busy(1'b1); wait_busy(1'b0); tick(2);
        `CHK(rd_data, 24'h000000)
        sc.continuous_acquire = 1'b0;
        for (int i = 0; i < 40 && acq !== 1'b0; i++) tick(1);
        `CHK(acq, 1'b0)
        // sample-count terminal in a single run
        sc.terminal_run_time = 12'h000;
        sc.terminal_sample_count = 32'h3;
        start = 1'b1; tick(1); start = 1'b0;
        `CHK(done, 1'b0)
        valid = 1'b1; tick(6); valid = 1'b0;
        `CHK(done, 1'b1)
        `CHK(acq, 1'b0)
        $display("statistics tests done");
        // modulated triggered: one rising event starts, stop ends
        meas = atc_pkg::MEAS_MODULATED;
        model.step(2'h1, 1'b0); tick(2); `CHK(acq, 1'b0)
        model.step(2'h1, 1'b1); tick(3); `CHK(acq, 1'b1)
        model.step(2'h1, 1'b0); tick(4); `CHK(acq, 1'b1)
        stop = 1'b1; tick(1); stop = 1'b0; tick(1);
        `CHK(acq, 1'b0)
        $display("modulated tests done");
        report_and_stop();
    end
endmodule
